// [hdl/rtcr_regs.vh]
// Register map, field widths, reset values and timing constants of the time-of-day readout block.
// Assumes it is included by bare name into the design files; it holds definitions only.
`ifndef RTCR_REGS_VH
`define RTCR_REGS_VH

// Byte addresses on the register bus.
`define RTCR_ADDR_NS_OFFSET 17'h1_2800
`define RTCR_ADDR_SEC_LO_OFFSET 17'h1_2808
`define RTCR_ADDR_SEC_HI_OFFSET 17'h1_280C
`define RTCR_ADDR_INCREMENT 17'h1_2810
`define RTCR_ADDR_NS_NOW 17'h1_2814
`define RTCR_ADDR_SEC_LO_NOW 17'h1_2818
`define RTCR_ADDR_SEC_HI_NOW 17'h1_281C
`define RTCR_ADDR_IRQ_CLEAR 17'h1_2820
`define RTCR_ADDR_PHASE 17'h1_2824

// Field widths.
`define RTCR_NS_W 30
`define RTCR_SEC_W 48
`define RTCR_SEC_HI_W 16
`define RTCR_INCR_W 26
`define RTCR_FRAC_W 20

// Reset values.
`define RTCR_RST_NS 30'h0000_0000
`define RTCR_RST_SEC 48'h0000_0000_0000
`define RTCR_RST_INCR 26'h000_0000
`define RTCR_RST_PHASE 30'h0000_0000

// Time constants in nanoseconds.
`define RTCR_NS_PER_SEC 30'h3B9A_CA00
`define RTCR_TICK_PERIOD_NS 17'h1_E848
`define RTCR_TICK_HALF_NS 17'h0_F424

// Bus response codes.
`define RTCR_RESP_OKAY 2'h0
`define RTCR_RESP_DECERR 2'h3

`endif

// [hdl/rtcr_tod_counter.v]
// Running time-of-day counter: 30-bit nanoseconds with a 20-bit fraction and 48-bit seconds.
// Assumes the increment and the offset values come from registers on the same clock.
`timescale 1ns/100ps
`include "rtcr_regs.vh"

module rtcr_tod_counter #(
	parameter NS_W = `RTCR_NS_W,
	parameter SEC_W = `RTCR_SEC_W,
	parameter INCR_W = `RTCR_INCR_W,
	parameter FRAC_W = `RTCR_FRAC_W
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [INCR_W-1:0] incr,
	input wire load_stb,
	input wire [NS_W-1:0] load_ns,
	input wire [SEC_W-1:0] load_sec,
	output wire [NS_W-1:0] ns_out,
	output wire [SEC_W-1:0] sec_out
);

	localparam ACC_W = NS_W + FRAC_W;

	reg [ACC_W-1:0] acc_reg;
	reg [ACC_W-1:0] acc_next;
	reg [SEC_W-1:0] sec_reg;
	reg [SEC_W-1:0] sec_next;
	wire [ACC_W:0] acc_sum;
	wire [ACC_W:0] wrap_limit;

	assign acc_sum = {1'b0, acc_reg} + {{(ACC_W+1-INCR_W){1'b0}}, incr}; // see R12
	assign wrap_limit = {1'b0, `RTCR_NS_PER_SEC, {FRAC_W{1'b0}}};

	// The increment stays far below one second, so a single subtraction always brings the count back in range.
	always @* begin
		acc_next = acc_sum[ACC_W-1:0];
		sec_next = sec_reg;
		if (load_stb) begin
			acc_next = {load_ns, {FRAC_W{1'b0}}}; // see R11
			sec_next = load_sec; // see R11
		end else if (acc_sum >= wrap_limit) begin
			acc_next = acc_sum[ACC_W-1:0] - wrap_limit[ACC_W-1:0]; // see R13
			sec_next = sec_reg + {{(SEC_W-1){1'b0}}, 1'b1}; // see R13
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			acc_reg <= {ACC_W{1'b0}};
			sec_reg <= `RTCR_RST_SEC;
		end else begin
			acc_reg <= acc_next;
			sec_reg <= sec_next;
		end
	end

	assign ns_out = acc_reg[ACC_W-1:FRAC_W];
	assign sec_out = sec_reg;

endmodule // rtcr_tod_counter

// [hdl/rtcr_readout.v]
// Register front end of the time-of-day counter: snapshot readout, periodic interrupt and phase-shifted tick.
// Assumes an AXI4-Lite master on core_clk and that the counter shares that clock.
//
// How it works
// R1 - Reading the nanoseconds-now register samples nanoseconds and seconds together.
// R2 - Seconds-now registers keep that sample until the next nanoseconds read.
// R3 - Nanoseconds-now returns the 30-bit count, upper two bits zero, reset zero.
// R4 - Seconds appear as low 32-bit and high 16-bit read-only words from the sample.
// R5 - Periodic timer interrupt stays high until software clears it.
// R6 - Any write to bit 0 of the clear register drops the interrupt, unless a tick rise sets it in that same cycle.
// R7 - The clear register always reads as zero.
// R8 - Phase offset is added to nanoseconds; derived outputs use the sum.
// R9 - The 8 kHz tick comes from the sum; half-period offset inverts it.
// R10 - The phase offset moves the tick in steps of one nanosecond.
// R11 - Writing the nanoseconds offset loads all three offsets into the counter at once.
// R12 - Each clock the counter adds a 26-bit increment in 2^-20 ns units.
// R13 - At one billion nanoseconds the count wraps and seconds advance by one.
// R14 - Snapshot and interrupt clear pass safely between counter and register logic.
`timescale 1ns/100ps
`include "rtcr_regs.vh"

module rtcr_readout #(
	parameter ADDR_W = 17,
	parameter NS_W = `RTCR_NS_W,
	parameter SEC_W = `RTCR_SEC_W,
	parameter INCR_W = `RTCR_INCR_W
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire timer_irq,
	output wire phase_tick_8khz
);

	// Merges the byte lanes selected by a strobe into an old register word.
	function [31:0] lane_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] strobe;
		integer i;
		begin
			lane_merge = old_word;
			for (i = 0; i < 4; i = i + 1) begin
				if (strobe[i]) begin
					lane_merge[i*8 +: 8] = new_word[i*8 +: 8];
				end
			end
		end
	endfunction

	// Tells whether an address hits one of the mapped register words.
	function addr_mapped;
		input [ADDR_W-1:0] addr;
		begin
			case (addr)
				`RTCR_ADDR_NS_OFFSET,
				`RTCR_ADDR_SEC_LO_OFFSET,
				`RTCR_ADDR_SEC_HI_OFFSET,
				`RTCR_ADDR_INCREMENT,
				`RTCR_ADDR_NS_NOW,
				`RTCR_ADDR_SEC_LO_NOW,
				`RTCR_ADDR_SEC_HI_NOW,
				`RTCR_ADDR_IRQ_CLEAR,
				`RTCR_ADDR_PHASE: addr_mapped = 1'b1;
				default: addr_mapped = 1'b0;
			endcase
		end
	endfunction

	// Write channel state.
	reg aw_full_reg;
	reg [ADDR_W-1:0] aw_addr_reg;
	reg w_full_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;

	// Read channel state.
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;

	// Software-visible storage.
	reg [NS_W-1:0] ns_offset_reg;
	reg [31:0] sec_lo_offset_reg;
	reg [`RTCR_SEC_HI_W-1:0] sec_hi_offset_reg;
	reg [INCR_W-1:0] incr_reg;
	reg [NS_W-1:0] phase_reg;
	reg [SEC_W-1:0] sec_snap_reg;
	reg load_stb_reg;

	// Timing outputs.
	reg [NS_W:0] phase_sum_reg;
	reg tick_reg;
	reg tick_prev_reg;
	reg irq_reg;

	wire [NS_W-1:0] ns_live;
	wire [SEC_W-1:0] sec_live;
	wire do_write;
	wire do_read;
	wire wr_hit;
	wire [NS_W:0] phase_mod_full;
	wire [16:0] phase_mod;
	wire tick_rise;
	wire irq_clear;
	wire [31:0] ns_off_merged;
	wire [31:0] sec_hi_merged;
	wire [31:0] incr_merged;
	wire [31:0] phase_merged;

	rtcr_tod_counter #(
		.NS_W(NS_W),
		.SEC_W(SEC_W),
		.INCR_W(INCR_W),
		.FRAC_W(`RTCR_FRAC_W)
	) u_counter (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.incr(incr_reg),
		.load_stb(load_stb_reg),
		.load_ns(ns_offset_reg),
		.load_sec({sec_hi_offset_reg, sec_lo_offset_reg}),
		.ns_out(ns_live),
		.sec_out(sec_live)
	);

	// Address and data are taken independently; each waits for the other before the write is done.
	assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
	assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_hit = addr_mapped(aw_addr_reg);

	always @(posedge core_clk) begin
		if (sys_rst) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= {ADDR_W{1'b0}};
			w_full_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `RTCR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? `RTCR_RESP_OKAY : `RTCR_RESP_DECERR;
			end else if (bvalid_reg & s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Narrow registers are merged as whole words and keep only their low bits, so reserved bits stay zero.
	assign ns_off_merged = lane_merge({2'b00, ns_offset_reg}, w_data_reg, w_strb_reg);
	assign sec_hi_merged = lane_merge({16'h0000, sec_hi_offset_reg}, w_data_reg, w_strb_reg);
	assign incr_merged = lane_merge({6'h00, incr_reg}, w_data_reg, w_strb_reg);
	assign phase_merged = lane_merge({2'b00, phase_reg}, w_data_reg, w_strb_reg);

	// Writable registers; only the byte lanes named by the strobe change.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ns_offset_reg <= `RTCR_RST_NS;
			sec_lo_offset_reg <= 32'h0000_0000;
			sec_hi_offset_reg <= 16'h0000;
			incr_reg <= `RTCR_RST_INCR;
			phase_reg <= `RTCR_RST_PHASE;
			load_stb_reg <= 1'b0;
		end else begin
			load_stb_reg <= 1'b0;
			if (do_write) begin
				case (aw_addr_reg)
					`RTCR_ADDR_NS_OFFSET: begin
						ns_offset_reg <= ns_off_merged[NS_W-1:0];
						load_stb_reg <= 1'b1; // see R11
					end
					`RTCR_ADDR_SEC_LO_OFFSET: begin
						sec_lo_offset_reg <= lane_merge(sec_lo_offset_reg, w_data_reg, w_strb_reg);
					end
					`RTCR_ADDR_SEC_HI_OFFSET: begin
						sec_hi_offset_reg <= sec_hi_merged[`RTCR_SEC_HI_W-1:0];
					end
					`RTCR_ADDR_INCREMENT: begin
						incr_reg <= incr_merged[INCR_W-1:0]; // see R12
					end
					`RTCR_ADDR_PHASE: begin
						phase_reg <= phase_merged[NS_W-1:0]; // see R8
					end
					default: begin
					end
				endcase
			end
		end
	end

	// The load strobe is registered, so the counter picks up the new offsets one cycle after the write is done.

	// Read channel: one request at a time, data one cycle after the address is taken.
	assign s_axi_arready = ~rvalid_reg;
	assign do_read = s_axi_arvalid & ~rvalid_reg;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `RTCR_RESP_OKAY;
			sec_snap_reg <= `RTCR_RST_SEC;
		end else begin
			if (do_read) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= addr_mapped(s_axi_araddr) ? `RTCR_RESP_OKAY : `RTCR_RESP_DECERR;
				case (s_axi_araddr)
					`RTCR_ADDR_NS_OFFSET: rdata_reg <= {2'b00, ns_offset_reg};
					`RTCR_ADDR_SEC_LO_OFFSET: rdata_reg <= sec_lo_offset_reg;
					`RTCR_ADDR_SEC_HI_OFFSET: rdata_reg <= {16'h0000, sec_hi_offset_reg};
					`RTCR_ADDR_INCREMENT: rdata_reg <= {6'h00, incr_reg};
					`RTCR_ADDR_NS_NOW: begin
						rdata_reg <= {2'b00, ns_live}; // see R3
						sec_snap_reg <= sec_live; // see R1
					end
					`RTCR_ADDR_SEC_LO_NOW: rdata_reg <= sec_snap_reg[31:0]; // see R2 see R4
					`RTCR_ADDR_SEC_HI_NOW: rdata_reg <= {16'h0000, sec_snap_reg[SEC_W-1:32]}; // see R4
					`RTCR_ADDR_IRQ_CLEAR: rdata_reg <= 32'h0000_0000; // see R7
					`RTCR_ADDR_PHASE: rdata_reg <= {2'b00, phase_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end else if (rvalid_reg & s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// The counter and this logic share core_clk, so sample and clear cross no clock boundary at all.
	assign irq_clear = do_write & (aw_addr_reg == `RTCR_ADDR_IRQ_CLEAR) & w_strb_reg[0]; // see R6 see R14

	// A second is a whole number of tick periods, so the wrap of the sum at one second need not be modelled.
	assign phase_mod_full = phase_sum_reg % {{(NS_W-16){1'b0}}, `RTCR_TICK_PERIOD_NS};
	assign phase_mod = phase_mod_full[16:0];
	assign tick_rise = tick_reg & ~tick_prev_reg;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			phase_sum_reg <= {(NS_W+1){1'b0}};
			tick_reg <= 1'b0;
			tick_prev_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			phase_sum_reg <= {1'b0, ns_live} + {1'b0, phase_reg}; // see R8 see R10
			tick_reg <= (phase_mod >= `RTCR_TICK_HALF_NS); // see R9
			tick_prev_reg <= tick_reg;
			if (tick_rise) begin
				irq_reg <= 1'b1; // see R5
			end else if (irq_clear) begin
				irq_reg <= 1'b0; // see R6
			end
		end
	end

	assign phase_tick_8khz = tick_reg;
	assign timer_irq = irq_reg;

endmodule // rtcr_readout

// [tb/rtcr_readout_properties.sv]
// Checker of the readout block: bus answers, readback fields, interrupt and tick.
// Assumes it is bound to rtcr_readout and sees only its ports.
`timescale 1ns/100ps
`include "rtcr_regs.vh"

module rtcr_readout_properties #(
	parameter ADDR_W = 17
) (
	input wire core_clk,
	input wire sys_rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire timer_irq,
	input wire phase_tick_8khz
);
	reg [ADDR_W-1:0] rd_addr_reg;
	reg [ADDR_W-1:0] wr_addr_reg;
	reg strb0_reg;
	wire clr_hit = wr_addr_reg == `RTCR_ADDR_IRQ_CLEAR && strb0_reg;

	// Addresses are remembered at the handshake because the master may drop them afterwards.
	always @(posedge core_clk) begin
		if (s_axi_arvalid && s_axi_arready)
			rd_addr_reg <= s_axi_araddr;
		if (s_axi_awvalid && s_axi_awready)
			wr_addr_reg <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready)
			strb0_reg <= s_axi_wstrb[0];
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
	chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	chk_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer moved");
	chk_ns_top_zero: assert property (
		s_axi_rvalid && rd_addr_reg == `RTCR_ADDR_NS_NOW |-> s_axi_rdata[31:30] == 2'h0) else $error("ns top set");
	chk_sec_hi_zero: assert property (
		s_axi_rvalid && rd_addr_reg == `RTCR_ADDR_SEC_HI_NOW |-> s_axi_rdata[31:16] == 16'h0000) else $error("sec hi top");
	chk_clear_reads_zero: assert property (
		s_axi_rvalid && rd_addr_reg == `RTCR_ADDR_IRQ_CLEAR |-> s_axi_rdata == 32'h0000_0000) else $error("clear read");
	chk_tick_sets_irq: assert property ($rose(phase_tick_8khz) |=> timer_irq) else $error("irq not set");
	chk_irq_holds: assert property ($fell(timer_irq) |-> $rose(s_axi_bvalid) && clr_hit)
		else $error("irq dropped alone");
	chk_clear_drops_irq: assert property ($rose(s_axi_bvalid) && clr_hit |->
		!timer_irq || ($past(phase_tick_8khz) && !$past(phase_tick_8khz, 2))) else $error("irq not cleared");

	cover property ($rose(timer_irq));
	cover property ($fell(timer_irq));
	cover property (s_axi_bvalid && s_axi_bresp == `RTCR_RESP_DECERR);
endmodule // rtcr_readout_properties

bind rtcr_readout rtcr_readout_properties #(.ADDR_W(ADDR_W)) u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.timer_irq(timer_irq), .phase_tick_8khz(phase_tick_8khz));

// [tb/test_rtcr_readout.sv]
// Self-checking bench of the readout block, driven as an AXI4-Lite master.
// Assumes the design files and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "rtcr_regs.vh"

module test_rtcr_readout;
	reg core_clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [16:0] s_axi_awaddr = 17'h0_0000, s_axi_araddr = 17'h0_0000;
	reg [31:0] s_axi_wdata = 32'h0000_0000;
	reg [3:0] s_axi_wstrb = 4'h0;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq, phase_tick_8khz;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer mismatches = 0, n_compared = 0, cycles = 0, i, k, n;
	reg [31:0] d;
	integer p [0:3];

	rtcr_readout dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq(timer_irq),
		.phase_tick_8khz(phase_tick_8khz));

	always #10 core_clk = ~core_clk;

	task results;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// The ceiling covers one full tick period plus all bus traffic.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t timeout", $time);
			results;
		end
	end

	task check(input [31:0] got, input [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Each task waits one edge first so that no signal is assigned twice in one time step.
	// Handshakes are judged on values settled before the edge, never on what that edge launches.
	task wr(input [16:0] a, input [31:0] v, input [3:0] s, input [1:0] er);
		reg done, aw_t, w_t, b_t;
		reg [1:0] resp;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge core_clk);
			aw_t = s_axi_awvalid & s_axi_awready;
			w_t = s_axi_wvalid & s_axi_wready;
			b_t = s_axi_bvalid & s_axi_bready;
			resp = s_axi_bresp;
			@(posedge core_clk);
			if (aw_t)
				s_axi_awvalid <= 1'b0;
			if (w_t)
				s_axi_wvalid <= 1'b0;
			if (b_t) begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				check(resp, er);
			end
		end
	endtask

	task rc(input [16:0] a, input [31:0] e, input [1:0] er, input cmp);
		reg done, ar_t, r_t;
		reg [1:0] resp;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge core_clk);
			ar_t = s_axi_arvalid & s_axi_arready;
			r_t = s_axi_rvalid & s_axi_rready;
			resp = s_axi_rresp;
			if (r_t)
				d = s_axi_rdata;
			@(posedge core_clk);
			if (ar_t)
				s_axi_arvalid <= 1'b0;
			if (r_t) begin
				done = 1'b1;
				s_axi_rready <= 1'b0;
				check(resp, er);
			end
		end
		if (cmp)
			check(d, e);
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		rc(`RTCR_ADDR_NS_NOW, 0, `RTCR_RESP_OKAY, 1);
		rc(`RTCR_ADDR_SEC_LO_NOW, 0, `RTCR_RESP_OKAY, 1);
		rc(`RTCR_ADDR_SEC_HI_NOW, 0, `RTCR_RESP_OKAY, 1);
		rc(`RTCR_ADDR_PHASE, 0, `RTCR_RESP_OKAY, 1);
		rc(17'h1_2804, 0, `RTCR_RESP_DECERR, 1);
		wr(17'h1_2804, 32'hFFFF_FFFF, 4'hF, `RTCR_RESP_DECERR);
		wr(`RTCR_ADDR_PHASE, 32'hFFFF_FFFF, 4'hF, `RTCR_RESP_OKAY);
		rc(`RTCR_ADDR_PHASE, 32'h3FFF_FFFF, `RTCR_RESP_OKAY, 1);
		wr(`RTCR_ADDR_PHASE, 32'h0000_0000, 4'hF, `RTCR_RESP_OKAY);
		$display("test reset_and_map done");
		wr(`RTCR_ADDR_INCREMENT, 32'h0140_0000, 4'hF, `RTCR_RESP_OKAY);
		wr(`RTCR_ADDR_SEC_LO_OFFSET, 32'h1234_5678, 4'hF, `RTCR_RESP_OKAY);
		wr(`RTCR_ADDR_SEC_HI_OFFSET, 32'hFFFF_ABCD, 4'hF, `RTCR_RESP_OKAY);
		wr(`RTCR_ADDR_NS_OFFSET, 32'h3B9A_C230, 4'hF, `RTCR_RESP_OKAY);
		rc(`RTCR_ADDR_NS_NOW, 0, `RTCR_RESP_OKAY, 0);
		check(d >= 999998000 && d < 1000000000 && d % 20 == 0, 1);
		repeat (150) @(posedge core_clk);
		rc(`RTCR_ADDR_SEC_LO_NOW, 32'h1234_5678, `RTCR_RESP_OKAY, 1);
		rc(`RTCR_ADDR_SEC_HI_NOW, 32'h0000_ABCD, `RTCR_RESP_OKAY, 1);
		rc(`RTCR_ADDR_NS_NOW, 0, `RTCR_RESP_OKAY, 0);
		check(d < 3000 && d % 20 == 0, 1);
		rc(`RTCR_ADDR_SEC_LO_NOW, 32'h1234_5679, `RTCR_RESP_OKAY, 1);
		$display("test snapshot_wrap done");
		wr(`RTCR_ADDR_IRQ_CLEAR, 32'h0000_0000, 4'h1, `RTCR_RESP_OKAY);
		i = 0;
		while (timer_irq !== 1'b1 && i < 7000) begin
			@(negedge core_clk);
			i = i + 1;
		end
		check(timer_irq, 1);
		rc(`RTCR_ADDR_IRQ_CLEAR, 0, `RTCR_RESP_OKAY, 1);
		check(timer_irq, 1);
		wr(`RTCR_ADDR_IRQ_CLEAR, 32'hFFFF_FFFE, 4'h1, `RTCR_RESP_OKAY);
		check(timer_irq, 0);
		$display("test interrupt done");
		wr(`RTCR_ADDR_INCREMENT, 32'h0000_0000, 4'hF, `RTCR_RESP_OKAY);
		rc(`RTCR_ADDR_NS_NOW, 0, `RTCR_RESP_OKAY, 0);
		n = d;
		p[0] = 0;
		p[1] = 62500;
		p[2] = (62499 + 125000 - n % 125000) % 125000;
		p[3] = p[2] + 1;
		for (k = 0; k < 4; k = k + 1) begin
			wr(`RTCR_ADDR_PHASE, p[k], 4'hF, `RTCR_RESP_OKAY);
			repeat (3) @(posedge core_clk);
			check(phase_tick_8khz, (n + p[k]) % 125000 >= 62500);
		end
		wr(`RTCR_ADDR_NS_NOW, 32'hFFFF_FFFF, 4'hF, `RTCR_RESP_OKAY);
		rc(`RTCR_ADDR_NS_NOW, n, `RTCR_RESP_OKAY, 1);
		$display("test phase done");
		results;
	end
endmodule // test_rtcr_readout
